// *** hdl/qcu_pkg.sv ***
package qcu_pkg;
    localparam int QCU_NUM_CH = 3;
    localparam int QCU_NUM_IN = 12;
    localparam int QCU_CNT_W = 32;
    localparam int QCU_MEAS_W = 32;
    localparam int QCU_CLK_MHZ = 200;
    localparam int QCU_MAX_RATE_KHZ = 10;
    // Shortest input half period at the top rate, in clock cycles.
    localparam int QCU_MIN_HALF_CYC =
        (QCU_CLK_MHZ * 1000) / (QCU_MAX_RATE_KHZ * 2);
    localparam logic [QCU_CNT_W-1:0] QCU_CNT_RST = 32'h0000_0000;
    localparam logic [QCU_MEAS_W-1:0] QCU_MEAS_RST = 32'h0000_0000;
    localparam logic [2:0] QCU_MODE_RST = 3'h0;
    localparam logic [1:0] QCU_IN_A = 2'h0;
    localparam logic [1:0] QCU_IN_B = 2'h1;
    // Per-pin special function for inputs one to six and nine to twelve.
    typedef enum logic [1:0] {
        QCU_FN_PLAIN,
        QCU_FN_COUNT,
        QCU_FN_METER,
        QCU_FN_IRQ
    } qcu_fn_e;
endpackage

// *** hdl/qcu_channel.sv ***
`timescale 1ns/1ps
module qcu_channel #(
    parameter int CNT_W = qcu_pkg::QCU_CNT_W,
    parameter int MEAS_W = qcu_pkg::QCU_MEAS_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Synchronised phases and setup
    input wire logic i_phase_a,
    input wire logic i_phase_b,
    input wire logic i_cnt_en,
    input wire logic i_meas_en,
    input wire logic i_enhanced,
    input wire logic i_target_load,
    input wire logic [CNT_W-1:0] i_target,
    // Results
    output logic [CNT_W-1:0] o_count,
    output logic o_match,
    output logic [MEAS_W-1:0] o_width,
    output logic [MEAS_W-1:0] o_period
);
    import qcu_pkg::*;

    typedef struct packed {
        logic a_prev;
        logic b_prev;
        logic [1:0] last_dir;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] target;
        logic match;
        logic [MEAS_W-1:0] run;
        logic [MEAS_W-1:0] width;
        logic [MEAS_W-1:0] period;
    } qcu_ch_s;

    qcu_ch_s st_q;
    qcu_ch_s st_d;

    function automatic logic [MEAS_W-1:0] qcu_inc(input logic [MEAS_W-1:0] v);
        qcu_inc = (v == '1) ? v : v + 1'b1;
    endfunction

    logic a_rise;
    logic b_rise;
    logic step_up;
    logic step_dn;

    always_comb begin
        st_d = st_q;
        st_d.a_prev = i_phase_a;
        st_d.b_prev = i_phase_b;
        a_rise = i_phase_a & ~st_q.a_prev;
        b_rise = i_phase_b & ~st_q.b_prev;
        step_up = 1'b0;
        step_dn = 1'b0;
        if (i_enhanced) begin
            // Full four-state decode: a back-and-forth jiggle cancels itself.
            if (i_phase_a != st_q.a_prev && i_phase_b == st_q.b_prev) begin
                step_up = (i_phase_a != i_phase_b);
                step_dn = (i_phase_a == i_phase_b);
            end else if (i_phase_b != st_q.b_prev &&
                         i_phase_a == st_q.a_prev) begin
                step_up = (i_phase_a == i_phase_b);
                step_dn = (i_phase_a != i_phase_b);
            end
            // Count only one step per full cycle: up at the A rising edge, down at the A falling edge.
            step_up = step_up & a_rise;
            step_dn = step_dn & (~i_phase_a & st_q.a_prev);
        end else begin
            // Simple decode: A rise with B low leads, B rise with A low lags.
            step_up = a_rise & ~i_phase_b;
            step_dn = b_rise & ~i_phase_a;
        end
        st_d.match = 1'b0;
        if (!i_cnt_en) begin
            st_d.count = QCU_CNT_RST;
        end else if (step_up) begin
            st_d.count = st_q.count + 1'b1;
        end else if (step_dn) begin
            st_d.count = st_q.count - 1'b1;
        end
        if (i_target_load) begin
            st_d.target = i_target;
        end
        st_d.match = i_cnt_en && (step_up || step_dn) &&
                     (st_d.count == st_q.target);
        // Width of the high phase and period between rising A edges.
        if (!i_meas_en) begin
            st_d.run = QCU_MEAS_RST;
            st_d.width = QCU_MEAS_RST;
            st_d.period = QCU_MEAS_RST;
        end else begin
            st_d.run = qcu_inc(st_q.run);
            if (~i_phase_a & st_q.a_prev) begin
                st_d.width = st_q.run;
            end
            if (a_rise) begin
                st_d.period = st_q.run;
                st_d.run = MEAS_W'(32'h0000_0001);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_count = st_q.count;
    assign o_match = st_q.match;
    assign o_width = st_q.width;
    assign o_period = st_q.period;
endmodule

// *** hdl/qcu_top.sv ***
`timescale 1ns/1ps
module qcu_top #(
    parameter int NUM_CH = qcu_pkg::QCU_NUM_CH,
    parameter int CNT_W = qcu_pkg::QCU_CNT_W,
    parameter int MEAS_W = qcu_pkg::QCU_MEAS_W
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // Raw digital inputs one to twelve (bit 0 is input one)
    input wire logic [qcu_pkg::QCU_NUM_IN-1:0] i_din,
    // Firmware commands, one cycle each, channel in i_cmd_ch
    input wire logic [1:0] i_cmd_ch,
    input wire logic i_counter_define_command,
    input wire logic i_counter_disable_command,
    input wire logic i_pulse_meter_enable_command,
    input wire logic i_target_load,
    input wire logic [CNT_W-1:0] i_target,
    // Interrupt selection per input, decode mode per channel
    input wire logic [qcu_pkg::QCU_NUM_IN-1:0] i_irq_sel,
    input wire logic [NUM_CH-1:0] i_system_setting_mode,
    // Plain input image and per-pin interrupt-edge pulses
    output logic [qcu_pkg::QCU_NUM_IN-1:0] o_plain_in,
    output logic [qcu_pkg::QCU_NUM_IN-1:0] o_irq_edge,
    // Channel results
    output logic [NUM_CH*CNT_W-1:0] o_counter_present_value,
    output logic [NUM_CH-1:0] o_match,
    output logic [NUM_CH*MEAS_W-1:0] o_width,
    output logic [NUM_CH*MEAS_W-1:0] o_period,
    output logic [NUM_CH-1:0] o_cnt_active,
    output logic [NUM_CH-1:0] o_meter_active
);
    import qcu_pkg::*;

    typedef struct packed {
        logic [QCU_NUM_IN-1:0] sync1;
        logic [QCU_NUM_IN-1:0] sync2;
        logic [QCU_NUM_IN-1:0] prev;
        logic [QCU_NUM_IN-1:0] irq_edge;
        logic [QCU_NUM_IN-1:0] plain;
        logic [NUM_CH-1:0] mode;
        logic [NUM_CH-1:0] cnt_en;
        logic [NUM_CH-1:0] meas_en;
    } qcu_top_s;

    qcu_top_s st_q;
    qcu_top_s st_d;

    // Input 7 and 8 have no special use; all inputs but these may interrupt.
    localparam logic [11:0] QCU_IRQ_OK = 12'hf3f;

    function automatic logic qcu_hit(input logic [1:0] ch, input int n);
        qcu_hit = (int'(ch) == n);
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.sync1 = i_din;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;
        st_d.mode = i_system_setting_mode;
        st_d.irq_edge = (st_q.sync2 ^ st_q.prev) & i_irq_sel &
                        QCU_IRQ_OK;
        for (int c = 0; c < NUM_CH; c++) begin
            if (qcu_hit(i_cmd_ch, c)) begin
                if (i_counter_define_command) begin
                    st_d.cnt_en[c] = 1'b1;
                    st_d.meas_en[c] = 1'b1;
                end else if (i_counter_disable_command) begin
                    st_d.cnt_en[c] = 1'b0;
                    st_d.meas_en[c] = 1'b0;
                end else if (i_pulse_meter_enable_command) begin
                    // Meter alone takes the pins from the counter.
                    st_d.cnt_en[c] = 1'b0;
                    st_d.meas_en[c] = 1'b1;
                end
            end
            // An interrupt pin drops counting and measuring on its channel.
            if (i_irq_sel[2*c] || i_irq_sel[2*c+1]) begin
                st_d.cnt_en[c] = 1'b0;
                st_d.meas_en[c] = 1'b0;
            end
        end
        // Every pin is readable as a plain input whatever its role.
        st_d.plain = st_q.sync2;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Each channel takes its fixed pin pair and has its own decoder.
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        qcu_channel #(
            .CNT_W(CNT_W),
            .MEAS_W(MEAS_W)
        ) u_ch (
            .i_sys_clk(i_sys_clk),
            .i_reset(i_reset),
            .i_phase_a(st_q.sync2[2*c]),
            .i_phase_b(st_q.sync2[2*c+1]),
            .i_cnt_en(st_q.cnt_en[c]),
            .i_meas_en(st_q.meas_en[c]),
            .i_enhanced(st_q.mode[c]),
            .i_target_load(i_target_load && qcu_hit(i_cmd_ch, c)),
            .i_target(i_target),
            .o_count(o_counter_present_value[c*CNT_W +: CNT_W]),
            .o_match(o_match[c]),
            .o_width(o_width[c*MEAS_W +: MEAS_W]),
            .o_period(o_period[c*MEAS_W +: MEAS_W])
        );
    end

    assign o_plain_in = st_q.plain;
    assign o_irq_edge = st_q.irq_edge;
    assign o_cnt_active = st_q.cnt_en;
    assign o_meter_active = st_q.meas_en;

    // One decode step per input change suffices at 10 kHz, far below clock.
    a_sync_delay: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        $past(i_reset) == 1'b0 |-> st_q.sync2 == $past(i_din, 2))
        else $error("synchroniser depth wrong");
    a_irq_kills: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        (i_irq_sel[0] || i_irq_sel[1]) |=>
        !o_cnt_active[0] && !o_meter_active[0])
        else $error("interrupt pin left counter on");
    a_define_meas: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[0] |-> o_meter_active[0])
        else $error("counter without measurement");
    a_define_on: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        i_counter_define_command && i_cmd_ch == 2'h2 &&
        !i_irq_sel[4] && !i_irq_sel[5] |=>
        o_cnt_active[2] && o_meter_active[2])
        else $error("define left channel off");
    a_disable_off: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        i_counter_disable_command && !i_counter_define_command &&
        i_cmd_ch == 2'h1 |=> !o_cnt_active[1] && !o_meter_active[1])
        else $error("disable left channel on");
    a_disable_clr: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !o_cnt_active[0] ##1 !o_cnt_active[0] |->
        o_counter_present_value[CNT_W-1:0] == '0)
        else $error("disabled counter not clear");
    a_meter_clr: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        !o_meter_active[0] ##1 !o_meter_active[0] |->
        o_width[MEAS_W-1:0] == '0 && o_period[MEAS_W-1:0] == '0)
        else $error("stopped meter not clear");
    a_meter_only: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        i_pulse_meter_enable_command && !i_counter_define_command &&
        i_cmd_ch == 2'h2 |=> !o_cnt_active[2])
        else $error("meter left counter running");
    a_mode_follow: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        ##1 st_q.mode == $past(i_system_setting_mode))
        else $error("mode not applied");
    a_irq_edge: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_irq_edge[6] == 1'b0 && o_irq_edge[7] == 1'b0)
        else $error("interrupt on pin without one");
    a_irq_source: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_irq_edge[8] |-> $past(i_irq_sel[8]))
        else $error("edge on pin not set as interrupt");
    a_plain_img: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        ##1 o_plain_in == $past(st_q.sync2))
        else $error("plain input image wrong");
    a_step_one: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[2] && $past(o_cnt_active[2]) |->
        o_counter_present_value[3*CNT_W-1 -: CNT_W] -
        $past(o_counter_present_value[3*CNT_W-1 -: CNT_W]) inside
        {32'h0, 32'h1, 32'hffff_ffff})
        else $error("count moved by more than one");
    a_pin_quiet: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[0] && $stable(st_q.sync2[1:0]) |=>
        $stable(o_counter_present_value[CNT_W-1:0]))
        else $error("count moved without a pin edge");
    a_up_step: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[0] && !st_q.mode[0] && $rose(st_q.sync2[0]) &&
        !st_q.sync2[1] |=> o_counter_present_value[CNT_W-1:0] ==
        $past(o_counter_present_value[CNT_W-1:0]) + 1'b1)
        else $error("leading phase did not count up");
    a_down_step: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[0] && !st_q.mode[0] && $rose(st_q.sync2[1]) &&
        !st_q.sync2[0] |=> o_counter_present_value[CNT_W-1:0] ==
        $past(o_counter_present_value[CNT_W-1:0]) - 1'b1)
        else $error("lagging phase did not count down");
    a_enh_back: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[1] && st_q.mode[1] && $fell(st_q.sync2[2]) &&
        !st_q.sync2[3] && $stable(st_q.sync2[3]) |=>
        o_counter_present_value[2*CNT_W-1:CNT_W] ==
        $past(o_counter_present_value[2*CNT_W-1:CNT_W]) - 1'b1)
        else $error("enhanced fall did not undo the step");
    a_enh_b_quiet: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_cnt_active[1] && st_q.mode[1] && $stable(st_q.sync2[2]) |=>
        $stable(o_counter_present_value[2*CNT_W-1:CNT_W]))
        else $error("enhanced count moved on a B edge");
    a_match_step: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_match[0] |-> $changed(o_counter_present_value[CNT_W-1:0]))
        else $error("match without a count step");
    a_match_en: assert property (@(posedge i_sys_clk)
        disable iff (i_reset)
        o_match[1] |-> $past(o_cnt_active[1]))
        else $error("match on a stopped counter");

    c_count: cover property (@(posedge i_sys_clk) o_match[0]);
    c_irq: cover property (@(posedge i_sys_clk) |o_irq_edge);
    c_enh: cover property (@(posedge i_sys_clk)
        st_q.mode[1] && o_cnt_active[1]);
    c_meter: cover property (@(posedge i_sys_clk)
        o_meter_active[2] && !o_cnt_active[2]);
    c_below: cover property (@(posedge i_sys_clk)
        o_counter_present_value[CNT_W-1:0] == '1);
endmodule

// *** tb/qcu_enc_model.sv ***
`timescale 1ns/1ps
module qcu_enc_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset,
    // One edge per step: 0 forward, 1 reverse, 2 jiggle A, 3 jiggle B
    input wire logic i_step,
    input wire logic [1:0] i_kind,
    // Phase outputs
    output logic o_phase_a,
    output logic o_phase_b
);
    logic [1:0] ab_q;
    // Only one phase moves per step, as a real disc does.
    always_ff @(posedge i_sys_clk) begin
        if (i_reset) begin
            ab_q <= 2'h0;
        end else if (i_step) begin
            case (i_kind)
                2'h0: ab_q <= {~ab_q[0], ab_q[1]};
                2'h1: ab_q <= {ab_q[0], ~ab_q[1]};
                2'h2: ab_q <= ab_q ^ 2'h2;
                default: ab_q <= ab_q ^ 2'h1;
            endcase
        end
    end
    assign o_phase_a = ab_q[1];
    assign o_phase_b = ab_q[0];
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_top;
    import qcu_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic [11:6] pins_q = 6'h0;
    logic [5:0] enc;
    logic [2:0] step = 3'h0;
    logic [1:0] kind = 2'h0;
    logic [1:0] ch = 2'h0;
    logic def = 0, dis = 0, met = 0, tld = 0;
    logic [31:0] tgt = 32'h0;
    logic [11:0] irq = 12'h0;
    logic [2:0] mode = 3'h0;
    logic [11:0] plain, iedge;
    logic [95:0] pv, wid, per;
    logic [2:0] mt, ca, ma;
    int miscompares = 0, n_tests = 0, cyc = 0, iseen = 0;
    int hits[3] = '{0, 0, 0};
    always #2.5 clk = ~clk;
    for (genvar g = 0; g < 3; g++) begin : g_enc
        qcu_enc_model i_enc (.i_sys_clk(clk), .i_reset(rst),
            .i_step(step[g]), .i_kind(kind),
            .o_phase_a(enc[2*g]), .o_phase_b(enc[2*g+1]));
    end
    qcu_top i_dut (.i_sys_clk(clk), .i_reset(rst), .i_din({pins_q, enc}),
        .i_cmd_ch(ch), .i_counter_define_command(def),
        .i_counter_disable_command(dis),
        .i_pulse_meter_enable_command(met), .i_target_load(tld),
        .i_target(tgt), .i_irq_sel(irq), .i_system_setting_mode(mode),
        .o_plain_in(plain), .o_irq_edge(iedge),
        .o_counter_present_value(pv), .o_match(mt), .o_width(wid),
        .o_period(per), .o_cnt_active(ca), .o_meter_active(ma));
    task summarize;
        $display("Tests %0d, miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog sized well above the roughly 1200 cycles the tests need.
    always @(posedge clk) begin
        cyc++;
        for (int c = 0; c < 3; c++) if (mt[c] === 1'b1) hits[c]++;
        if (iedge[8] === 1'b1) iseen++;
        if (iedge[6] === 1'b1) iseen++;
        if (cyc == 20000) begin
            miscompares++;
            summarize();
        end
    end
    function automatic logic [31:0] cnt(input int c);
        return pv[32*c+:32];
    endfunction
    task automatic cmd(input int k, input int c);
        @(posedge clk);
        ch <= c[1:0];
        case (k)
            0: def <= 1;
            1: dis <= 1;
            2: met <= 1;
            default: tld <= 1;
        endcase
        @(posedge clk);
        {def, dis, met, tld} <= 4'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic restart(input int c);
        cmd(1, c);
        cmd(0, c);
    endtask
    // Edges 8 clocks apart leave room for the 3-cycle pin-to-count delay.
    task automatic move(input logic [2:0] m, input logic [1:0] k,
                        input int n);
        repeat (n) begin
            @(posedge clk);
            step <= m;
            kind <= k;
            @(posedge clk);
            step <= 3'h0;
            repeat (6) @(posedge clk);
        end
    endtask
    task automatic t_dir;
        for (int c = 0; c < 3; c++) begin
            restart(c);
            move(3'(1 << c), 2'h1, 4);
            `CHK(cnt(c), 32'hffff_ffff)
            move(3'(1 << c), 2'h0, 12);
            `CHK(cnt(c), 32'h2)
            `CHK(wid[32*c+:32], 32'h10)
            `CHK(per[32*c+:32], 32'h20)
            `CHK({ca[c], ma[c]}, 2'h3)
        end
        for (int c = 0; c < 3; c++) `CHK(cnt(c), 32'h2)
        $display("done: direction");
    endtask
    task automatic t_single;
        for (int c = 0; c < 3; c++) begin
            restart(c);
            move(3'(1 << c), 2'h2, 6);
            `CHK(cnt(c), 32'h3)
            move(3'(1 << c), 2'h3, 6);
            `CHK(cnt(c), 32'h0)
        end
        $display("done: single phase");
    endtask
    task automatic t_enh;
        for (int c = 0; c < 3; c++) begin
            mode <= 3'(1 << c);
            for (int k = 0; k < 3; k++) restart(k);
            move(3'h7, 2'h2, 6);
            for (int k = 0; k < 3; k++)
                `CHK(cnt(k), (k == c) ? 32'h0 : 32'h3)
            move(3'h7, 2'h0, 4);
            `CHK(cnt(c), 32'h1)
        end
        mode <= 3'h0;
        $display("done: enhanced");
    endtask
    task automatic t_match;
        restart(1);
        tgt <= 32'h2;
        cmd(3, 1);
        hits = '{0, 0, 0};
        move(3'h2, 2'h0, 8);
        `CHK(hits[1], 1)
        `CHK(hits[0] + hits[2], 0)
        tgt <= 32'h3;
        cmd(3, 1);
        move(3'h2, 2'h0, 4);
        `CHK(hits[1], 2)
        $display("done: match");
    endtask
    task automatic t_pins;
        cmd(2, 2);
        `CHK({ca[2], ma[2]}, 2'h1)
        @(posedge clk);
        irq[0] <= 1'b1;
        irq[8] <= 1'b1;
        irq[6] <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK({ca[0], ma[0]}, 2'h0)
        pins_q[8] <= 1'b1;
        pins_q[6] <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(iseen, 1)
        `CHK(plain[6], 1'b1)
        cmd(1, 1);
        `CHK({cnt(1), ca[1]}, 33'h0)
        $display("done: pins");
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({pv, ca}, 99'h0)
        t_dir();
        t_single();
        t_enh();
        t_match();
        t_pins();
        summarize();
    end
endmodule
